// >>> logic/pbcs_consts.svh
// register offsets, field positions, reset values and counts of the base clock select block
`ifndef PBCS_CONSTS_SVH
`define PBCS_CONSTS_SVH

`define PBCS_ADDR_W 2
`define PBCS_DATA_W 8

`define PBCS_OFF_CTRL 2'h0
`define PBCS_OFF_BWC 2'h1
`define PBCS_OFF_PROG 2'h2

// pll_control fields
`define PBCS_CTL_IE 7
`define PBCS_CTL_FLAG 6
`define PBCS_CTL_ON 5
`define PBCS_CTL_SEL 4
`define PBCS_CTL_LOW_ONES 4'hF

// bandwidth_control fields
`define PBCS_BWC_AUTO 7
`define PBCS_BWC_LOCK 6
`define PBCS_BWC_ACQ 5
`define PBCS_BWC_LOSS 4

// programming register fields
`define PBCS_PROG_MUL_HI 7
`define PBCS_PROG_MUL_LO 4
`define PBCS_PROG_RANGE_HI 3
`define PBCS_PROG_RANGE_LO 0
`define PBCS_MUL_RST 4'h6
`define PBCS_RANGE_RST 4'h6
`define PBCS_RANGE_OFF 4'h0

// source edges seen on each clock before a switch completes
`define PBCS_SW_EDGES 2'h3

`endif

// >>> logic/pbcs_ctrl.sv
// base clock selector, pll control and bandwidth control registers
`timescale 1ns/1ps
`default_nettype none
`include "pbcs_consts.svh"

module pbcs_ctrl (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [`PBCS_ADDR_W-1:0] reg_addr,
    input wire logic [`PBCS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`PBCS_DATA_W-1:0] reg_rdata,
    input wire logic crystal_clock,
    input wire logic vco_clock,
    input wire logic lock_detect,
    input wire logic track_detect,
    input wire logic stop_req,
    input wire logic oscillator_enable,
    output logic base_clock_out,
    output logic clockgen_irq,
    output logic pll_enable,
    output logic filter_track,
    output logic vco_selected
);

////////////////////////////////////////////////////////////////////////////////

logic lock_irq_enable_r;
logic lock_change_flag_r;
logic pll_on_a_r;
logic base_clock_select_r;
logic auto_r;
logic lock_r;
logic acq_man_r;
logic acq_auto_r;
logic crystal_loss_detect_r;
logic [3:0] mul_r;
logic [3:0] range_r;
logic xclk_q;
logic vclk_q;
logic act_sel_r;
logic [1:0] x_cnt_r;
logic [1:0] v_cnt_r;
pbcs_pkg::pbcs_sw_e sw_state_r;

logic wr_ctrl;
logic wr_bwc;
logic wr_prog;
logic rd_ctrl;
logic range_zero;
logic x_rise;
logic v_rise;
logic lock_nxt;
logic src_rise;
logic sw_done;

assign wr_ctrl = reg_wr && (reg_addr == `PBCS_OFF_CTRL);
assign wr_bwc = reg_wr && (reg_addr == `PBCS_OFF_BWC);
assign wr_prog = reg_wr && (reg_addr == `PBCS_OFF_PROG);
assign rd_ctrl = reg_rd && (reg_addr == `PBCS_OFF_CTRL);
assign range_zero = (range_r == `PBCS_RANGE_OFF);
assign x_rise = crystal_clock && !xclk_q;
assign v_rise = vco_clock && !vclk_q;
assign lock_nxt = auto_r && lock_detect;
assign src_rise = act_sel_r ? v_rise : x_rise;
assign sw_done = (x_cnt_r == `PBCS_SW_EDGES) && (v_cnt_r == `PBCS_SW_EDGES);

// saturating count of source edges during a switch
function automatic logic [1:0] edge_count(input logic [1:0] cnt, input logic rise);
    if (rise && cnt != `PBCS_SW_EDGES) begin
        edge_count = cnt + 2'h1;
    end else begin
        edge_count = cnt;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pll control register

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        lock_irq_enable_r <= 1'b0;
    end else if (wr_ctrl && auto_r) begin
        lock_irq_enable_r <= reg_wdata[`PBCS_CTL_IE];
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        pll_on_a_r <= 1'b1;
    end else if (wr_ctrl) begin
        // clearing is refused while base clock select is set
        if (reg_wdata[`PBCS_CTL_ON] || !base_clock_select_r) begin
            pll_on_a_r <= reg_wdata[`PBCS_CTL_ON];
        end
    end
end

// the select bit looks at pll on before this write, so on and select
// cannot both rise in one write
always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        base_clock_select_r <= 1'b0;
    end else if (stop_req || range_zero) begin
        base_clock_select_r <= 1'b0;
    end else if (wr_ctrl) begin
        if (!reg_wdata[`PBCS_CTL_SEL] || pll_on_a_r) begin
            base_clock_select_r <= reg_wdata[`PBCS_CTL_SEL];
        end
    end
end

// a toggle in the same cycle as a read keeps the flag set
always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        lock_change_flag_r <= 1'b0;
    end else if (!auto_r) begin
        lock_change_flag_r <= 1'b0;
    end else if (lock_nxt != lock_r) begin
        lock_change_flag_r <= 1'b1;
    end else if (rd_ctrl) begin
        lock_change_flag_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// bandwidth control register

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        auto_r <= 1'b0;
    end else if (wr_bwc) begin
        auto_r <= reg_wdata[`PBCS_BWC_AUTO];
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        lock_r <= 1'b0;
    end else begin
        lock_r <= lock_nxt;
    end
end

// manual value is held untouched while automatic mode runs
always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        acq_man_r <= 1'b0;
    end else if (wr_bwc && !auto_r) begin
        acq_man_r <= reg_wdata[`PBCS_BWC_ACQ];
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        acq_auto_r <= 1'b0;
    end else begin
        acq_auto_r <= auto_r && track_detect;
    end
end

// set by software, cleared by a crystal edge seen while base clock select is set, unless a write lands in the same cycle
always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        crystal_loss_detect_r <= 1'b0;
    end else if (!base_clock_select_r) begin
        crystal_loss_detect_r <= 1'b0;
    end else if (wr_bwc) begin
        crystal_loss_detect_r <= reg_wdata[`PBCS_BWC_LOSS];
    end else if (x_rise) begin
        crystal_loss_detect_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// programming register

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        mul_r <= `PBCS_MUL_RST;
    end else if (wr_prog && !pll_on_a_r) begin
        mul_r <= reg_wdata[`PBCS_PROG_MUL_HI:`PBCS_PROG_MUL_LO];
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        range_r <= `PBCS_RANGE_RST;
    end else if (wr_prog && !pll_on_a_r) begin
        range_r <= reg_wdata[`PBCS_PROG_RANGE_HI:`PBCS_PROG_RANGE_LO];
    end
end

////////////////////////////////////////////////////////////////////////////////
// read port: data stands only in the cycle after the strobe

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        reg_rdata <= '0;
    end else if (reg_rd) begin
        case (reg_addr)
            `PBCS_OFF_CTRL: begin
                reg_rdata <= {lock_irq_enable_r && auto_r, lock_change_flag_r,
                              pll_on_a_r, base_clock_select_r,
                              `PBCS_CTL_LOW_ONES};
            end
            `PBCS_OFF_BWC: begin
                // test bits are not implemented and read zero
                reg_rdata <= {auto_r, lock_r,
                              auto_r ? acq_auto_r : acq_man_r,
                              crystal_loss_detect_r && base_clock_select_r,
                              4'h0};
            end
            `PBCS_OFF_PROG: begin
                reg_rdata <= {mul_r, range_r};
            end
            default: begin
                reg_rdata <= '0;
            end
        endcase
    end else begin
        reg_rdata <= '0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// base clock selector

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        xclk_q <= 1'h0;
    end else begin
        xclk_q <= crystal_clock;
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        vclk_q <= 1'h0;
    end else begin
        vclk_q <= vco_clock;
    end
end

// both sources must show three edges, except the vco on a return to crystal with the pll disabled; a vco that never ticks still stalls
// a switch to it, which is why select cannot rise while the pll is off
always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        sw_state_r <= pbcs_pkg::PBCS_RUN;
    end else begin
        case (sw_state_r)
            pbcs_pkg::PBCS_RUN: begin
                if (base_clock_select_r != act_sel_r) begin
                    sw_state_r <= pbcs_pkg::PBCS_SWITCH;
                end
            end
            pbcs_pkg::PBCS_SWITCH: begin
                if (sw_done) begin
                    sw_state_r <= pbcs_pkg::PBCS_RUN;
                end
            end
            default: begin
                sw_state_r <= pbcs_pkg::PBCS_RUN;
            end
        endcase
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        act_sel_r <= 1'h0;
    end else if (sw_state_r == pbcs_pkg::PBCS_SWITCH && sw_done) begin
        act_sel_r <= base_clock_select_r;
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        x_cnt_r <= 2'h0;
    end else if (sw_state_r == pbcs_pkg::PBCS_SWITCH) begin
        x_cnt_r <= edge_count(x_cnt_r, x_rise);
    end else begin
        x_cnt_r <= 2'h0;
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        v_cnt_r <= 2'h0;
    end else if (sw_state_r != pbcs_pkg::PBCS_SWITCH) begin
        v_cnt_r <= 2'h0;
    end else if (!base_clock_select_r && !pll_enable) begin
        // a vco turned off right after deselection must not hang the return to crystal
        v_cnt_r <= `PBCS_SW_EDGES;
    end else begin
        v_cnt_r <= edge_count(v_cnt_r, v_rise);
    end
end

// crystal return under stop still waits for three crystal edges: stop holds the output low meanwhile
always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        base_clock_out <= 1'b0;
    end else if (stop_req) begin
        base_clock_out <= 1'b0;
    end else if (sw_state_r == pbcs_pkg::PBCS_RUN && src_rise) begin
        base_clock_out <= !base_clock_out;
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        vco_selected <= 1'b0;
    end else begin
        vco_selected <= act_sel_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// analogue controls and interrupt

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        pll_enable <= 1'h0;
    end else begin
        pll_enable <= pll_on_a_r && !range_zero && oscillator_enable && !stop_req;
    end
end

always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        filter_track <= 1'h0;
    end else begin
        filter_track <= auto_r ? track_detect : acq_man_r;
    end
end

// one cycle behind the flag and the enable
always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        clockgen_irq <= 1'b0;
    end else begin
        clockgen_irq <= lock_change_flag_r && lock_irq_enable_r && auto_r && !stop_req;
    end
end

endmodule
`default_nettype wire

// >>> logic/pbcs_pkg.sv
// types shared by the base clock select block
`default_nettype none
package pbcs_pkg;

typedef enum logic [0:0] {
    PBCS_RUN,
    PBCS_SWITCH
} pbcs_sw_e;

endpackage
`default_nettype wire

// >>> verification/pbcs_ctrl_asserts.sv
// pin-level assertions for the base clock select block
`timescale 1ns/1ps
`default_nettype none
module pbcs_ctrl_asserts (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    input wire logic lock_detect,
    input wire logic stop_req,
    input wire logic oscillator_enable,
    input wire logic base_clock_out,
    input wire logic clockgen_irq,
    input wire logic pll_enable
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_b);
rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
low_ones_a:
    assert property ($past(reg_rd) && $past(reg_addr) == 2'h0 |-> reg_rdata[3:0] == 4'hF)
        else $error("control low bits not ones");
test_bits_a:
    assert property ($past(reg_rd) && $past(reg_addr) == 2'h1 |-> reg_rdata[3:0] == 4'h0)
        else $error("bandwidth test bits not zero");
unmapped_read_a:
    assert property ($past(reg_rd) && $past(reg_addr) == 2'h3 |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
// lock held still around the read and no write just before it, so no fresh
// toggle (from the detector or from a mode change) can set the flag again
irq_clear_a:
    assert property ($stable(lock_detect)[*3] ##0 (reg_rd && reg_addr == 2'h0 && !$past(reg_wr))
        |-> ##2 !clockgen_irq) else $error("interrupt kept after control read");
stop_quiet_a:
    assert property (stop_req |=> !base_clock_out && !clockgen_irq && !pll_enable)
        else $error("outputs active during stop");
half_period_a:
    assert property ($changed(base_clock_out) && !stop_req |=> $stable(base_clock_out))
        else $error("base clock toggled twice in a row");
osc_off_a:
    assert property (!oscillator_enable |=> !pll_enable) else $error("pll on without oscillator");
endmodule
`default_nettype wire

// >>> verification/pbcs_pll_model.sv
// crystal oscillator, vco and lock detector facing the control block
`timescale 1ns/1ps
`default_nettype none
module pbcs_pll_model (
    input wire logic pll_enable,
    input wire logic xtal_run,
    input wire logic lock_cmd,
    input wire logic track_cmd,
    output logic crystal_clock,
    output logic vco_clock,
    output logic lock_detect,
    output logic track_detect
);
initial crystal_clock = 1'b0;
initial vco_clock = 1'b0;
// a dead crystal simply holds its level
always #80 crystal_clock = xtal_run ? ~crystal_clock : crystal_clock;
// vco stands low while the loop is off
always #60 vco_clock = pll_enable ? ~vco_clock : 1'b0;
assign lock_detect = pll_enable & lock_cmd;
assign track_detect = pll_enable & track_cmd;
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the base clock select block
`timescale 1ns/1ps
`default_nettype none
bind pbcs_ctrl pbcs_ctrl_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .lock_detect(lock_detect),
    .stop_req(stop_req),
    .oscillator_enable(oscillator_enable), .base_clock_out(base_clock_out),
    .clockgen_irq(clockgen_irq), .pll_enable(pll_enable));
module testbench;
logic sys_clk, rst_b, reg_wr, reg_rd, stop_req, oscillator_enable, xtal_run, lock_cmd, track_cmd;
logic [1:0] reg_addr;
logic [7:0] reg_wdata, reg_rdata;
logic crystal_clock, vco_clock, lock_detect, track_detect;
logic base_clock_out, clockgen_irq, pll_enable, filter_track, vco_selected;
int error_cnt = 0;
int compares = 0;
pbcs_ctrl i_pbcs_ctrl (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .crystal_clock(crystal_clock), .vco_clock(vco_clock), .lock_detect(lock_detect),
    .track_detect(track_detect), .stop_req(stop_req), .oscillator_enable(oscillator_enable),
    .base_clock_out(base_clock_out), .clockgen_irq(clockgen_irq), .pll_enable(pll_enable),
    .filter_track(filter_track), .vco_selected(vco_selected));
pbcs_pll_model i_pbcs_pll_model (.pll_enable(pll_enable), .xtal_run(xtal_run),
    .lock_cmd(lock_cmd), .track_cmd(track_cmd), .crystal_clock(crystal_clock),
    .vco_clock(vco_clock), .lock_detect(lock_detect), .track_detect(track_detect));
initial sys_clk = 1'b0;
always #10 sys_clk = ~sys_clk;
////////////////////////////////////////////////////////////////
task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
        error_cnt++;
        $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
endtask
// one strobe cycle, then a released cycle, so calls never collide on an edge
task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
endtask
task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
endtask
task automatic rd(input logic [1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk($sformatf("reg %0h", a), e, reg_rdata);
endtask
task automatic wsel(input logic v);
    int n;
    n = 0;
    while (vco_selected !== v && n < 200) begin
        @(posedge sys_clk);
        #1;
        n++;
    end
    chk("vco selected", {7'h00, v}, {7'h00, vco_selected});
endtask
// cycles between two base clock toggles
task automatic per(input int p);
    int n;
    logic b;
    @(posedge sys_clk);
    #1;
    b = base_clock_out;
    n = 0;
    while (base_clock_out === b && n < 50) begin
        @(posedge sys_clk);
        #1;
        n++;
    end
    b = base_clock_out;
    n = 0;
    while (base_clock_out === b && n < 50) begin
        @(posedge sys_clk);
        #1;
        n++;
    end
    chk("base half period", p[7:0], n[7:0]);
endtask
////////////////////////////////////////////////////////////////
task automatic t_reset;
    rd(2'h0, 8'h2F);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h66);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    per(8);
endtask
task automatic t_select;
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h0F);
    wr(2'h0, 8'h30);
    rd(2'h0, 8'h2F);
    wr(2'h2, 8'h12);
    rd(2'h2, 8'h66);
    wr(2'h0, 8'h30);
    wr(2'h0, 8'h10);
    rd(2'h0, 8'h3F);
    wsel(1'b1);
    per(6);
    xtal_run <= 1'b0;
    wr(2'h1, 8'h10);
    repeat (24) @(posedge sys_clk);
    rd(2'h1, 8'h10);
    xtal_run <= 1'b1;
    repeat (24) @(posedge sys_clk);
    rd(2'h1, 8'h00);
    wr(2'h0, 8'h20);
    wsel(1'b0);
    per(8);
    wr(2'h1, 8'h10);
    rd(2'h1, 8'h00);
endtask
task automatic t_range;
    wr(2'h0, 8'h00);
    wr(2'h2, 8'h60);
    wr(2'h0, 8'h20);
    wr(2'h0, 8'h30);
    rd(2'h0, 8'h2F);
    chk("pll enable", 8'h00, {7'h00, pll_enable});
    wr(2'h0, 8'h00);
    wr(2'h2, 8'h66);
    wr(2'h0, 8'h20);
endtask
task automatic t_lock;
    wr(2'h1, 8'h20);
    rd(2'h1, 8'h20);
    chk("filter track", 8'h01, {7'h00, filter_track});
    wr(2'h0, 8'hA0);
    rd(2'h0, 8'h2F);
    wr(2'h1, 8'hA0);
    rd(2'h1, 8'h80);
    wr(2'h0, 8'hA0);
    rd(2'h0, 8'hAF);
    chk("filter track", 8'h00, {7'h00, filter_track});
    lock_cmd <= 1'b1;
    track_cmd <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("irq", 8'h01, {7'h00, clockgen_irq});
    rd(2'h1, 8'hE0);
    rd(2'h0, 8'hEF);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("irq", 8'h00, {7'h00, clockgen_irq});
    rd(2'h0, 8'hAF);
    wr(2'h1, 8'h20);
    rd(2'h1, 8'h20);
    chk("filter track", 8'h01, {7'h00, filter_track});
    rd(2'h0, 8'h2F);
    lock_cmd <= 1'b0;
    track_cmd <= 1'b0;
endtask
task automatic t_stop;
    wr(2'h0, 8'h30);
    wsel(1'b1);
    stop_req <= 1'b1;
    oscillator_enable <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("base out", 8'h00, {7'h00, base_clock_out});
    @(posedge sys_clk);
    stop_req <= 1'b0;
    oscillator_enable <= 1'b1;
    rd(2'h0, 8'h2F);
endtask
task automatic conclude;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask
initial begin
    {reg_wr, reg_rd, stop_req, lock_cmd, track_cmd, rst_b} = 6'h00;
    {oscillator_enable, xtal_run} = 2'h3;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset;
    t_select;
    t_range;
    t_lock;
    t_stop;
    conclude;
end
// the whole sequence needs well under a tenth of this
initial begin
    #200000;
    error_cnt++;
    conclude;
end
endmodule
`default_nettype wire
